// file: src/tsc_pkg.sv
// package: register map, field layout, reset values and codes of the timer status/counter block
`default_nettype none
package tsc_pkg;
    // register byte addresses (one aligned word each)
    localparam logic [7:0] TSC_OFS_CTRL    = 8'h00; // timer_status_control
    localparam logic [7:0] TSC_OFS_CNT_HI  = 8'h04; // count_high_byte
    localparam logic [7:0] TSC_OFS_CNT_LO  = 8'h08; // count_low_byte
    localparam logic [7:0] TSC_OFS_MODULO  = 8'h0c; // modulo_value, 16 bits
    localparam logic [7:0] TSC_OFS_STATUS  = 8'h10; // live status: irq, direction
    // status/control field positions
    localparam int TSC_BIT_OVF    = 7;
    localparam int TSC_BIT_OVIE   = 6;
    localparam int TSC_BIT_CENTER = 5;
    localparam int TSC_CLKS_HI    = 4;
    localparam int TSC_CLKS_LO    = 3;
    localparam int TSC_PS_HI      = 2;
    localparam int TSC_PS_LO      = 0;
    // reset values
    localparam logic [7:0]  TSC_CTRL_RST = 8'h00;
    localparam logic [15:0] TSC_CNT_RST  = 16'h0000;
    localparam logic [15:0] TSC_MOD_RST  = 16'h0000;
    // clock source codes
    typedef enum logic [1:0] {
        TSC_SRC_OFF,
        TSC_SRC_BUS,
        TSC_SRC_FIXED,
        TSC_SRC_EXT
    } tsc_src_e;
    // axi response codes
    localparam logic [1:0] TSC_RESP_OK     = 2'h0;
    localparam logic [1:0] TSC_RESP_SLVERR = 2'h2;
    // control fields carried together
    typedef struct packed {
        logic       ovie;
        logic       center;
        tsc_src_e   src;
        logic [2:0] ps;
    } tsc_ctrl_s;
endpackage : tsc_pkg
`default_nettype wire

// file: src/tsc_tick_gen.sv
// tick generator: source select, external sync, power-of-two prescaler
`default_nettype none
module tsc_tick_gen
    import tsc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire tsc_src_e   src,          // selected clock source
    input  wire logic [2:0] ps,           // prescale code
    input  wire logic       fixed_tick,   // fixed clock pulse, already synced
    input  wire logic       pll_enabled,  // fixed clock meaningful only if set
    input  wire logic       ext_clk,      // raw external clock pin
    input  wire logic       freeze,       // debug freeze
    output logic            tick          // one-cycle counter enable
);
    logic       ext_s1;     // first sync stage, read only by ext_s2
    logic       ext_s2;     // second sync stage
    logic       ext_s3;     // edge detect history
    logic [6:0] pre_cnt;    // prescaler count
    logic       src_pulse;  // selected source pulse
    logic       ext_rise;   // synced rising edge
    logic       pre_hit;    // prescaler terminal
    logic [6:0] pre_mask;   // low bits that must be all ones

    assign ext_rise = ext_s2 & ~ext_s3;
    // no pll: fixed source falls back to bus rate
    assign src_pulse = (src == TSC_SRC_BUS)   ? 1'b1 :
                       (src == TSC_SRC_FIXED) ? (pll_enabled ? fixed_tick : 1'b1) :
                       (src == TSC_SRC_EXT)   ? ext_rise : 1'b0;
    // ps read directly, so a new code acts next cycle
    assign pre_mask = 7'((8'h01 << ps) - 8'h01);
    assign pre_hit  = (pre_cnt & pre_mask) == pre_mask;

    // external pin synchroniser on the bus clock
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end
        else
        begin
            ext_s1 <= ext_clk;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // prescaler counts source pulses after selection
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            pre_cnt <= 7'h00;
            tick    <= 1'b0;
        end
        else
        begin
            tick <= src_pulse & pre_hit & ~freeze;
            if (src_pulse && !freeze)
                pre_cnt <= pre_hit ? 7'h00 : 7'(pre_cnt + 7'h01);
        end
    end
endmodule : tsc_tick_gen
`default_nettype wire

// file: src/tsc_timer.sv
// timer status/control and 16-bit counter behind an axi4-lite slave
// Contract
// - set overflow flag on wrap to zero
// - clear flag by read-set then write zero
// - overflow during clear sequence restarts it
// - writing one keeps flag; reset clears it
// - irq when flag and enable set
// - center select gives up/down counting
// - decode two-bit clock source field
// - synchronise external clock to bus clock
// - fixed clock equals bus without pll
// - prescale divides by two to the code
// - prescaler follows source selection
// - new prescale acts next cycle
// - byte read latches both counter bytes
// - control write restarts read latch
// - counter write clears counter and latch
// - reset clears counter bytes
// - debug freezes counter and read latch
// - writes reset latch even in debug
// - wrap after modulo; zero is free-run
`default_nettype none
module tsc_timer
    import tsc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // system side
    input  wire logic        background_debug_active,
    input  wire logic        fixed_tick,
    input  wire logic        pll_enabled,
    input  wire logic        ext_clk,
    output logic             overflow_irq,
    output logic             center_align_select,
    output logic [15:0]      count_value
);
    logic        overflow_flag;  // sticky overflow status
    tsc_ctrl_s   ctrl;           // control fields
    logic [15:0] count;          // live counter
    logic [15:0] modulo_value;   // wrap point, zero means free run
    logic        count_down;     // direction in center mode
    logic        ovf_armed;      // read of status/control seen with flag set
    logic [15:0] latch_buf;      // coherent read snapshot
    logic        latch_full;     // one half read, other pending
    logic        tick;           // prescaled counter enable
    logic        aw_held;        // write address captured
    logic        w_held;         // write data captured
    logic [7:0]  aw_addr;        // captured write address
    logic [31:0] w_data;         // captured write data
    logic [3:0]  w_strb;         // captured strobes
    logic        dbg;            // debug freeze shorthand

    assign dbg = background_debug_active;
    // count step; tick is registered, so gate debug and source off here as well
    wire        step      = tick & ~dbg & (ctrl.src != TSC_SRC_OFF);

    // write decode once both channels are in
    wire        wr_go     = aw_held & w_held & ~s_axi_bvalid;
    wire        wr_lane0  = w_strb[0];
    wire        wr_ctrl   = wr_go & (aw_addr == TSC_OFS_CTRL) & wr_lane0;
    wire        wr_cnt    = wr_go & ((aw_addr == TSC_OFS_CNT_HI) ||
                                     (aw_addr == TSC_OFS_CNT_LO));
    wire        wr_mod    = wr_go & (aw_addr == TSC_OFS_MODULO);
    wire        wr_known  = (aw_addr == TSC_OFS_CTRL) || (aw_addr == TSC_OFS_CNT_HI) ||
                            (aw_addr == TSC_OFS_CNT_LO) || (aw_addr == TSC_OFS_MODULO) ||
                            (aw_addr == TSC_OFS_STATUS);
    // read decode
    wire        rd_go     = s_axi_arvalid & s_axi_arready;
    wire        rd_ctrl   = rd_go & (s_axi_araddr == TSC_OFS_CTRL);
    wire        rd_cnt    = rd_go & ((s_axi_araddr == TSC_OFS_CNT_HI) ||
                                     (s_axi_araddr == TSC_OFS_CNT_LO));
    wire [15:0] cnt_view  = latch_full ? latch_buf : count;
    // wrap point: modulo reached, or all ones when free running
    wire        at_top    = (modulo_value == TSC_MOD_RST) ? (count == 16'hffff)
                                                          : (count == modulo_value);
    wire        at_bottom = (count == TSC_CNT_RST);
    // overflow event: up mode wraps to zero, center mode turns at top
    wire        ovf_event = step & at_top & ~wr_cnt;
    wire [7:0]  ctrl_byte = {overflow_flag, ctrl.ovie, ctrl.center, ctrl.src, ctrl.ps};
    wire        rd_known  = (s_axi_araddr == TSC_OFS_CTRL) ||
                            (s_axi_araddr == TSC_OFS_CNT_HI) ||
                            (s_axi_araddr == TSC_OFS_CNT_LO) ||
                            (s_axi_araddr == TSC_OFS_MODULO) ||
                            (s_axi_araddr == TSC_OFS_STATUS);
    wire [31:0] rd_word   = (s_axi_araddr == TSC_OFS_CTRL)   ? {24'h0, ctrl_byte} :
                            (s_axi_araddr == TSC_OFS_CNT_HI) ? {24'h0, cnt_view[15:8]} :
                            (s_axi_araddr == TSC_OFS_CNT_LO) ? {24'h0, cnt_view[7:0]} :
                            (s_axi_araddr == TSC_OFS_MODULO) ? {16'h0, modulo_value} :
                            (s_axi_araddr == TSC_OFS_STATUS) ?
                                {30'h0, count_down, overflow_irq} : 32'h0;

    tsc_tick_gen u_tick
    (
        .core_clk    (core_clk),
        .resetn      (resetn),
        .src         (ctrl.src),
        .ps          (ctrl.ps),
        .fixed_tick  (fixed_tick),
        .pll_enabled (pll_enabled),
        .ext_clk     (ext_clk),
        .freeze      (dbg),
        .tick        (tick)
    );

    // write channel capture, either order accepted
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end
        else
        begin
            s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_go)
                w_held <= 1'b0;
        end
    end

    // write response, slverr on an unmapped address
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= TSC_RESP_OK;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? TSC_RESP_OK : TSC_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read channel: one read in flight, answer one cycle after arready
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= TSC_RESP_OK;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_known ? TSC_RESP_OK : TSC_RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // control fields and modulo; reset clears all controls
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            ctrl         <= tsc_ctrl_s'(TSC_CTRL_RST[6:0]);
            modulo_value <= TSC_MOD_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= tsc_ctrl_s'(w_data[TSC_BIT_OVIE:TSC_PS_LO]);
            if (wr_mod)
                modulo_value <= w_data[15:0];
        end
    end

    // overflow flag: set wins over clear, clear needs armed read
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            overflow_flag <= 1'b0;
            ovf_armed     <= 1'b0;
        end
        else if (ovf_event)
        begin
            overflow_flag <= 1'b1;
            ovf_armed     <= 1'b0;
        end
        else
        begin
            if (rd_ctrl && overflow_flag)
                ovf_armed <= 1'b1;
            // writing one leaves the flag alone
            if (wr_ctrl && ovf_armed && !w_data[TSC_BIT_OVF])
            begin
                overflow_flag <= 1'b0;
                ovf_armed     <= 1'b0;
            end
        end
    end

    // counter; frozen in debug through the tick gate
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            count      <= TSC_CNT_RST;
            count_down <= 1'b0;
        end
        else if (wr_cnt)
        begin
            count      <= TSC_CNT_RST;
            count_down <= 1'b0;
        end
        else if (step)
        begin
            // count per tick only while a source is on
            if (!ctrl.center)
                count <= at_top ? TSC_CNT_RST : 16'(count + 16'h0001);
            else if (count_down)
            begin
                // up/down center-aligned counting
                count      <= at_bottom ? 16'h0001 : 16'(count - 16'h0001);
                count_down <= ~at_bottom;
            end
            else
            begin
                count      <= at_top ? 16'(count - 16'h0001) : 16'(count + 16'h0001);
                count_down <= at_top;
            end
        end
    end

    // coherent read latch
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            latch_full <= 1'b0;
            latch_buf  <= TSC_CNT_RST;
        end
        else if (wr_ctrl || wr_cnt)
            latch_full <= 1'b0;
        else if (rd_cnt && !dbg)
        begin
            // reads in debug leave the latch state untouched
            latch_full <= ~latch_full;
            if (!latch_full)
                latch_buf <= count;
        end
    end

    // registered outputs
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            overflow_irq        <= 1'b0;
            center_align_select <= 1'b0;
            count_value         <= TSC_CNT_RST;
        end
        else
        begin
            overflow_irq        <= overflow_flag & ctrl.ovie;
            center_align_select <= ctrl.center;
            count_value         <= count;
        end
    end

    // flag sets one cycle after a wrap tick
    a_ovf_set: assert property (@(posedge core_clk) disable iff (!resetn)
        ovf_event |=> overflow_flag) else $error("overflow flag not set");
    // clear needs a prior armed read
    a_ovf_clear: assert property (@(posedge core_clk) disable iff (!resetn)
        $fell(overflow_flag) |-> $past(ovf_armed)) else $error("flag cleared unarmed");
    // irq follows flag and enable
    a_irq_follow: assert property (@(posedge core_clk) disable iff (!resetn)
        (overflow_flag && ctrl.ovie) |=> overflow_irq) else $error("irq missing");
    // counter holds when source off
    a_cnt_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        (ctrl.src == TSC_SRC_OFF && !wr_cnt) ##1 (ctrl.src == TSC_SRC_OFF)
        |-> $stable(count)) else $error("counter moved while off");
    // debug freeze holds counter
    a_dbg_freeze: assert property (@(posedge core_clk) disable iff (!resetn)
        (dbg && !wr_cnt) [*2] |-> $stable(count)) else $error("counter moved in debug");
    // counter write clears value and latch
    a_cnt_clear: assert property (@(posedge core_clk) disable iff (!resetn)
        wr_cnt |=> (count == TSC_CNT_RST) && !latch_full) else $error("write no clear");
    // control write restarts latch
    a_latch_rst: assert property (@(posedge core_clk) disable iff (!resetn)
        wr_ctrl |=> !latch_full) else $error("latch not restarted");
    // up mode wraps to zero at the top
    a_up_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
        (step && at_top && !ctrl.center && !wr_cnt) |=> (count == TSC_CNT_RST))
        else $error("no wrap at top");

    c_overflow:  cover property (@(posedge core_clk) ovf_event);
    c_clear_seq: cover property (@(posedge core_clk) $fell(overflow_flag));
    c_latched:   cover property (@(posedge core_clk) rd_cnt && latch_full);
    c_down:      cover property (@(posedge core_clk) $rose(count_down));
endmodule : tsc_timer
`default_nettype wire

// file: tb/tsc_timer_tb_top.sv
// testbench for the timer status/control register and 16-bit counter
`default_nettype none
module tsc_timer_tb_top
    import tsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // clock, reset and axi master side
    logic        core_clk      = 1'b0;
    logic        resetn        = 1'b0;
    logic [7:0]  s_axi_awaddr  = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [3:0]  s_axi_wstrb   = 4'h0;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready  = 1'b0;
    logic [7:0]  s_axi_araddr  = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready  = 1'b0;
    // system side
    logic        background_debug_active = 1'b0;
    logic        fixed_tick    = 1'b0;
    logic        pll_enabled   = 1'b0;
    logic        ext_clk       = 1'b0;
    logic        overflow_irq;
    logic        center_align_select;
    logic [15:0] count_value;
    // bookkeeping
    int          error_cnt       = 0;
    int          samples_checked = 0;
    logic [31:0] cyc             = 32'h0; // free cycle count for side clocks
    logic [31:0] rd_dat;                  // scratch for raw read data
    logic        dn;                      // down-count seen

    tsc_timer u_dut (
        .core_clk(core_clk), .resetn(resetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .background_debug_active(background_debug_active), .fixed_tick(fixed_tick),
        .pll_enabled(pll_enabled), .ext_clk(ext_clk), .overflow_irq(overflow_irq),
        .center_align_select(center_align_select), .count_value(count_value)
    );

    // 100 MHz core clock
    always #5 core_clk = ~core_clk;

    // fixed pulse every 4th cycle; external clock period 8 cycles, within the sync limit
    always @(posedge core_clk)
    begin
        cyc        <= cyc + 32'h1;
        fixed_tick <= (cyc[1:0] == 2'h3);
        ext_clk    <= cyc[2];
    end

    // exact compare, four-state safe
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // range compare; an unknown never lands inside the range
    task automatic chk_rng(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                           input logic [31:0] got);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            error_cnt++;
            $display("unexpected %s expected %0h..%0h seen %0h", nm, lo, hi, got);
        end
    endtask : chk_rng

    // one write: address and data offered together, each dropped when taken
    task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= 4'h1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1 && n < 100);
        chk("bvalid", 1, s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : axi_write

    // one read: rready held until rvalid is sampled
    task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1 && n < 100);
        chk("rvalid", 1, s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : axi_read

    // read a mapped register and check its data against a range
    task automatic rd(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
        logic [31:0] d;
        axi_read(a, TSC_RESP_OK, d);
        chk_rng("rdata", lo, hi, d);
    endtask : rd

    // wait for the counter to show a value, bounded
    task automatic wait_cnt(input logic [15:0] v);
        int n;
        n = 0;
        while (count_value !== v && n < 5000)
        begin
            @(posedge core_clk);
            n++;
        end
        chk("count reached", {16'h0, v}, {16'h0, count_value});
    endtask : wait_cnt

    // counts gained over 1024 cycles under a given control value
    task automatic rate(input logic [7:0] ctl, input logic [31:0] lo, input logic [31:0] hi);
        logic [15:0] c0;
        logic [15:0] dl;
        axi_write(TSC_OFS_CTRL, ctl, TSC_RESP_OK);
        repeat (16) @(posedge core_clk);
        c0 = count_value;
        repeat (1024) @(posedge core_clk);
        dl = count_value - c0;
        chk_rng("count rate", lo, hi, {16'h0, dl});
    endtask : rate

    // watch 64 cycles for a decrement that is not a wrap to zero
    task automatic dir_seen(output logic dn_o);
        logic [15:0] prev;
        dn_o = 1'b0;
        prev = count_value;
        repeat (64)
        begin
            @(posedge core_clk);
            if (count_value < prev && count_value != 16'h0)
                dn_o = 1'b1;
            prev = count_value;
        end
    endtask : dir_seen

    // single end of run
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // hang guard, well beyond the ~19k cycles the sequence needs
    initial
    begin
        repeat (60000) @(posedge core_clk);
        error_cnt++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        // reset values and an unmapped place
        rd(TSC_OFS_CTRL, 0, 0);
        rd(TSC_OFS_CNT_HI, 0, 0);
        rd(TSC_OFS_CNT_LO, 0, 0);
        axi_read(8'h14, TSC_RESP_SLVERR, rd_dat);
        chk("unmapped rdata", 0, rd_dat);
        axi_write(8'h14, 8'hff, TSC_RESP_SLVERR);
        // source select and prescaler, free-running counter
        rate(8'h00, 0, 0);
        for (int k = 0; k < 8; k++)
        begin
            rate(8'h08 | 8'(k), (1024 >> k) - 1, (1024 >> k) + 1);
        end
        rate(8'h10, 1023, 1025);
        pll_enabled <= 1'b1;
        rate(8'h10, 255, 257);
        rate(8'h11, 127, 129);
        rate(8'h18, 127, 129);
        rate(8'h1a, 31, 33);
        // overflow flag with modulo 0x40
        axi_write(TSC_OFS_MODULO, 8'h40, TSC_RESP_OK);
        rd(TSC_OFS_MODULO, 32'h40, 32'h40);
        axi_write(TSC_OFS_CNT_HI, 8'ha5, TSC_RESP_OK);
        axi_write(TSC_OFS_CTRL, 8'h48, TSC_RESP_OK);
        wait_cnt(16'h0030);
        wait_cnt(16'h0005);
        rd(TSC_OFS_CTRL, 32'hc8, 32'hc8);
        chk("irq", 1, overflow_irq);
        rd(TSC_OFS_STATUS, 1, 1);
        axi_write(TSC_OFS_CTRL, 8'hc8, TSC_RESP_OK);
        rd(TSC_OFS_CTRL, 32'hc8, 32'hc8);
        wait_cnt(16'h0030);
        wait_cnt(16'h0005);
        axi_write(TSC_OFS_CTRL, 8'h48, TSC_RESP_OK);
        rd(TSC_OFS_CTRL, 32'hc8, 32'hc8);
        wait_cnt(16'h0020);
        rd(TSC_OFS_CTRL, 32'hc8, 32'hc8);
        axi_write(TSC_OFS_CTRL, 8'h48, TSC_RESP_OK);
        rd(TSC_OFS_CTRL, 32'h48, 32'h48);
        chk("irq", 0, overflow_irq);
        wait_cnt(16'h0005);
        axi_write(TSC_OFS_CTRL, 8'h08, TSC_RESP_OK);
        rd(TSC_OFS_CTRL, 32'h88, 32'h88);
        chk("irq", 0, overflow_irq);
        // up/down against up-only counting, modulo 0x10
        axi_write(TSC_OFS_MODULO, 8'h10, TSC_RESP_OK);
        axi_write(TSC_OFS_CNT_LO, 8'h00, TSC_RESP_OK);
        axi_write(TSC_OFS_CTRL, 8'h28, TSC_RESP_OK);
        repeat (2) @(posedge core_clk);
        chk("center", 1, center_align_select);
        dir_seen(dn);
        chk("down count", 1, dn);
        axi_write(TSC_OFS_CTRL, 8'h08, TSC_RESP_OK);
        repeat (2) @(posedge core_clk);
        chk("center", 0, center_align_select);
        dir_seen(dn);
        chk("down count", 0, dn);
        // read latch, free-running at one count per cycle
        axi_write(TSC_OFS_MODULO, 8'h00, TSC_RESP_OK);
        axi_write(TSC_OFS_CNT_HI, 8'h5a, TSC_RESP_OK);
        rd(TSC_OFS_CNT_LO, 0, 32'h20);
        repeat (600) @(posedge core_clk);
        rd(TSC_OFS_CNT_HI, 0, 0);
        axi_write(TSC_OFS_CNT_LO, 8'h5a, TSC_RESP_OK);
        rd(TSC_OFS_CNT_HI, 0, 0);
        repeat (600) @(posedge core_clk);
        rd(TSC_OFS_CNT_LO, 0, 32'h20);
        axi_write(TSC_OFS_CNT_LO, 8'h00, TSC_RESP_OK);
        rd(TSC_OFS_CNT_HI, 0, 0);
        axi_write(TSC_OFS_CNT_HI, 8'hff, TSC_RESP_OK);
        repeat (600) @(posedge core_clk);
        rd(TSC_OFS_CNT_LO, 32'h50, 32'h90);
        rd(TSC_OFS_CNT_HI, 2, 2);
        axi_write(TSC_OFS_CNT_LO, 8'h00, TSC_RESP_OK);
        rd(TSC_OFS_CNT_HI, 0, 0);
        axi_write(TSC_OFS_CTRL, 8'h08, TSC_RESP_OK);
        repeat (600) @(posedge core_clk);
        rd(TSC_OFS_CNT_LO, 32'h50, 32'h90);
        rd(TSC_OFS_CNT_HI, 2, 2);
        // debug freeze: counter holds, control write still empties the latch
        axi_write(TSC_OFS_CNT_LO, 8'h00, TSC_RESP_OK);
        rd(TSC_OFS_CNT_LO, 0, 32'h20);
        repeat (300) @(posedge core_clk);
        background_debug_active <= 1'b1;
        axi_write(TSC_OFS_CTRL, 8'h08, TSC_RESP_OK);
        rd(TSC_OFS_CNT_HI, 1, 1);
        repeat (200) @(posedge core_clk);
        rd(TSC_OFS_CNT_LO, 32'h20, 32'h50);
        // reads in debug leave a half-read pair alone
        background_debug_active <= 1'b0;
        axi_write(TSC_OFS_CNT_LO, 8'h00, TSC_RESP_OK);
        rd(TSC_OFS_CNT_HI, 0, 0);
        repeat (300) @(posedge core_clk);
        background_debug_active <= 1'b1;
        axi_read(TSC_OFS_CNT_LO, TSC_RESP_OK, rd_dat);
        axi_read(TSC_OFS_CNT_HI, TSC_RESP_OK, rd_dat);
        background_debug_active <= 1'b0;
        rd(TSC_OFS_CNT_LO, 0, 32'h20);
        print_verdict();
    end
endmodule : tsc_timer_tb_top
`default_nettype wire
